// *** logic/conversion_count_store.sv ***
/*
 * Counting and result-storage path of a digitising meter: clock divider,
 * decade counter, conversion pulse control, polarity flag and digit memory.
 * Assumes zero crossing and polarity inputs synchronous to core_clk_i,
 * and time-slot selection from the readout logic.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccs_cfg.svh"

module conversion_count_store
    import ccs_pkg::*;
#(
    parameter int OSC_DIV = `CCS_OSC_DIV
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic zero_cross_i,
    input wire logic input_negative_i,
    input wire logic [1:0] slot_i,
    output logic last_count_o,
    output logic temp_trig_o,
    output logic conv_pulse_o,
    output logic store_cmd_o,
    output logic [3:0] digit_o,
    output logic minus_n_o
);

    localparam int DIV_W = $clog2(OSC_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);

    // One counter stage: returns {carry, next digit}
    function automatic logic [4:0] stage_step(input logic [3:0] d, input logic [3:0] top, input logic en);
        if (!en) begin
            return {1'b0, d};
        end
        if (d == top) begin
            return {1'b1, 4'h0};
        end
        return {1'b0, d + 4'h1};
    endfunction

    // ----------------------------------------
    // Oscillator and divide by two
    // ----------------------------------------
    logic [DIV_W-1:0] osc_cnt_q, osc_cnt_d;
    logic half_q, half_d;
    logic osc_tick, count_tick;

    always_comb begin
        osc_tick = (osc_cnt_q == DIV_LAST);
        osc_cnt_d = osc_tick ? '0 : osc_cnt_q + 1'b1;
        half_d = half_q ^ osc_tick;
        count_tick = osc_tick && half_q;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_cnt_q <= '0;
            half_q <= 1'b0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            half_q <= half_d;
        end
    end

    // ----------------------------------------
    // Decade counter
    // ----------------------------------------
    bcd_count_t cnt_q, cnt_d;
    logic last_q, last_d;
    logic trig_q, trig_d;
    logic [4:0] s0, s1, s2, s3;

    // Free-running; no hold input because conversions repeat every cycle
    always_comb begin
        s0 = stage_step(cnt_q.ones, `CCS_DECADE_TOP, count_tick);
        s1 = stage_step(cnt_q.tens, `CCS_DECADE_TOP, s0[4]);
        s2 = stage_step(cnt_q.hund, `CCS_DECADE_TOP, s1[4]);
        s3 = stage_step(cnt_q.thou, `CCS_EIGHT_TOP, s2[4]);
        cnt_d = '{thou: s3[3:0], hund: s2[3:0], tens: s1[3:0], ones: s0[3:0]};
        last_d = s3[4];
        trig_d = s0[4] && !cnt_q.tens[0];
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
            last_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            last_q <= last_d;
            trig_q <= trig_d;
        end
    end

    // ----------------------------------------
    // Conversion pulse and polarity
    // ----------------------------------------
    conv_state_t state_q, state_d;
    logic conv_q, conv_d;
    logic store_q, store_d;
    logic minus_n_q, minus_n_d;

    // A new full count wins over a late zero crossing: restart, never store stale
    always_comb begin
        state_d = state_q;
        store_d = 1'b0;
        minus_n_d = minus_n_q;
        unique case (state_q)
            CONV_IDLE: begin
                if (last_q) begin
                    state_d = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (!last_q && zero_cross_i) begin
                    state_d = CONV_IDLE;
                    store_d = 1'b1;
                    minus_n_d = !input_negative_i;
                end
            end
            default: state_d = CONV_IDLE;
        endcase
        conv_d = (state_d == CONV_RUN);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= CONV_IDLE;
            conv_q <= 1'b0;
            store_q <= 1'b0;
            minus_n_q <= `CCS_MINUS_N_RST;
        end else begin
            state_q <= state_d;
            conv_q <= conv_d;
            store_q <= store_d;
            minus_n_q <= minus_n_d;
        end
    end

    // ----------------------------------------
    // Digit memory
    // ----------------------------------------
    digit_store u_store (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .count_tick_i(count_tick),
        .store_req_i(store_q),
        .count_i(cnt_q),
        .slot_i(slot_i),
        .digit_o(digit_o)
    );

    assign last_count_o = last_q;
    assign temp_trig_o = trig_q;
    assign conv_pulse_o = conv_q;
    assign store_cmd_o = store_q;
    assign minus_n_o = minus_n_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    logic [13:0] gap_q;
    logic [DIV_W:0] tick_gap_q;
    logic seen_q;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_q <= '0;
            tick_gap_q <= '0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= last_q ? 14'h0 : gap_q + {13'h0, count_tick};
            tick_gap_q <= count_tick ? '0 : tick_gap_q + 1'b1;
            seen_q <= seen_q | last_q;
        end
    end

    full_count_gap_a: assert property (last_d && seen_q |-> gap_q == `CCS_FULL_COUNT - 14'h1)
        else $error("full count period wrong");
    // Gap counter starts with the divider, so the first tick after reset is spaced alike
    tick_spacing_a: assert property (count_tick |-> tick_gap_q == (DIV_W + 1)'(2 * OSC_DIV - 1))
        else $error("counter tick spacing wrong");
    wrap_zero_a: assert property (last_q |-> cnt_q == '0)
        else $error("counter did not wrap to zero");
    stage_range_a: assert property (cnt_q.ones <= `CCS_DECADE_TOP && cnt_q.tens <= `CCS_DECADE_TOP
        && cnt_q.hund <= `CCS_DECADE_TOP && cnt_q.thou <= `CCS_EIGHT_TOP)
        else $error("counter stage out of range");
    temp_trig_a: assert property (temp_trig_o |-> cnt_q.ones == 4'h0 && cnt_q.tens[0])
        else $error("trigger not on second decade");
    conv_start_a: assert property (last_count_o |=> conv_pulse_o)
        else $error("conversion did not start");
    conv_end_a: assert property (conv_pulse_o && zero_cross_i && !last_count_o |=> !conv_pulse_o && store_cmd_o)
        else $error("conversion end without store");
    minus_flag_a: assert property (store_cmd_o |-> minus_n_o == !$past(input_negative_i))
        else $error("polarity flag wrong");
    minus_hold_a: assert property (!store_cmd_o |-> $stable(minus_n_o))
        else $error("polarity flag moved without store");

    conv_done_c: cover property (last_count_o ##[1:1000] store_cmd_o);
    neg_result_c: cover property (store_cmd_o && !minus_n_o);
    restart_c: cover property (conv_pulse_o && last_count_o);

endmodule
`default_nettype wire

// *** logic/ccs_cfg.svh ***
/*
 * Constants of the conversion count store: timing, counter stage limits,
 * time-slot codes and reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCS_CLK_HZ 40000000
`define CCS_OSC_HZ 80000
`define CCS_OSC_DIV (`CCS_CLK_HZ / `CCS_OSC_HZ)
`define CCS_TRIG_HZ 2000

// ----------------------------------------
// Counter stages
// ----------------------------------------
`define CCS_FULL_COUNT 14'h1f40
`define CCS_DECADE_TOP 4'h9
`define CCS_EIGHT_TOP 4'h7

// ----------------------------------------
// Time slots and reset values
// ----------------------------------------
`define CCS_SLOT_ONES 2'h0
`define CCS_SLOT_TENS 2'h1
`define CCS_SLOT_HUND 2'h2
`define CCS_SLOT_THOU 2'h3
`define CCS_DIGIT_RST 4'h0
`define CCS_MINUS_N_RST 1'b1

`endif

// *** logic/ccs_pkg.sv ***
/*
 * Types shared by the conversion count store modules.
 * Assumes nothing of its surroundings.
 */
package ccs_pkg;

    // BCD count, 1-2-4-8 weighted digits
    typedef struct packed {
        logic [3:0] thou;
        logic [3:0] hund;
        logic [3:0] tens;
        logic [3:0] ones;
    } bcd_count_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_t;

endpackage

// *** logic/digit_store.sv ***
/*
 * Store strobe delay stage, digit storage registers and time-slot multiplexer.
 * Assumes a one-cycle store request and a one-cycle counter tick on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ccs_cfg.svh"

module digit_store
    import ccs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic count_tick_i,
    input wire logic store_req_i,
    input wire bcd_count_t count_i,
    input wire logic [1:0] slot_i,
    output logic [3:0] digit_o
);

    // ----------------------------------------
    // Delay stage and storage
    // ----------------------------------------
    logic pend_q, pend_d;
    bcd_count_t stored_q, stored_d;
    logic [3:0] digit_q, digit_d;
    logic load;

    // Capture waits for a counter tick so the count has settled
    always_comb begin
        load = pend_q && count_tick_i;
        pend_d = pend_q;
        if (load) begin
            pend_d = 1'b0;
        end
        if (store_req_i) begin
            pend_d = 1'b1;
        end
        stored_d = stored_q;
        if (load) begin
            stored_d = count_i;
        end
        unique case (slot_i)
            `CCS_SLOT_ONES: digit_d = stored_q.ones;
            `CCS_SLOT_TENS: digit_d = stored_q.tens;
            `CCS_SLOT_HUND: digit_d = stored_q.hund;
            `CCS_SLOT_THOU: digit_d = stored_q.thou;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_q <= 1'b0;
            stored_q <= '0;
            digit_q <= `CCS_DIGIT_RST;
        end else begin
            pend_q <= pend_d;
            stored_q <= stored_d;
            digit_q <= digit_d;
        end
    end

    assign digit_o = digit_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    strobe_not_direct_a: assert property (store_req_i && !pend_q |=> $stable(stored_q))
        else $error("store strobe loaded digits without delay");
    digits_capture_a: assert property (pend_q && count_tick_i |=> stored_q == $past(count_i))
        else $error("digits not captured from counter");
    digits_hold_a: assert property (!pend_q |=> $stable(stored_q))
        else $error("digits changed without strobe");
    slot_digit_a: assert property (slot_i == `CCS_SLOT_THOU |=> digit_o == $past(stored_q.thou))
        else $error("slot digit mismatch");

endmodule
`default_nettype wire

// *** tb/readout_model.sv ***
/*
 * Readout logic model: walks the time slots, keeps the last digit seen
 * for each slot and one sign, the last seen in any slot.
 * Assumes digit_i follows slot_o one clock later.
 */
`timescale 1ns/100ps
`default_nettype none

module readout_model
    import ccs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] digit_i,
    input wire logic minus_n_i,
    output logic [1:0] slot_o,
    output bcd_count_t shown_o,
    output logic minus_shown_o
);
    // ----------------------------------------
    // Slot walk, two clocks a slot
    // ----------------------------------------
    logic [2:0] cyc_q;

    assign slot_o = cyc_q[2:1];

    // Capture on the second clock, once digit_o has settled
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc_q <= 3'h0;
            shown_o <= '0;
            minus_shown_o <= 1'b0;
        end else begin
            cyc_q <= cyc_q + 3'h1;
            if (cyc_q[0]) begin
                shown_o[cyc_q[2:1] * 4 +: 4] <= digit_i;
                minus_shown_o <= !minus_n_i;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/test_conversion_count_store.sv ***
/*
 * Self-checking bench of the conversion count store.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module test_conversion_count_store
    import ccs_pkg::*;
;
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    // Short divider keeps two full counts near 64k clocks
    localparam int DIV = 2;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic zero_cross = 1'b0;
    logic input_negative = 1'b0;
    logic [1:0] slot;
    logic [3:0] digit;
    logic last_count, temp_trig, conv_pulse, store_cmd, minus_n, minus_shown;
    bcd_count_t shown;
    int bad_count = 0;
    int tests_run = 0;
    int gap = 0;
    int lc_gap = 0;

    always #12.5 core_clk = ~core_clk;

    conversion_count_store #(.OSC_DIV(DIV)) u_dut (.core_clk_i(core_clk), .rstn_i(rstn),
        .zero_cross_i(zero_cross), .input_negative_i(input_negative), .slot_i(slot),
        .last_count_o(last_count), .temp_trig_o(temp_trig), .conv_pulse_o(conv_pulse),
        .store_cmd_o(store_cmd), .digit_o(digit), .minus_n_o(minus_n));

    readout_model u_readout (.core_clk_i(core_clk), .rstn_i(rstn), .digit_i(digit),
        .minus_n_i(minus_n), .slot_o(slot), .shown_o(shown), .minus_shown_o(minus_shown));

    always @(posedge core_clk) begin
        if (last_count === 1'b1) begin
            lc_gap <= gap;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_hi(input int which, output int n);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while ((which == 0 ? last_count : temp_trig) !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            bad_count++;
            wrap_up();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        rstn <= 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        check("reset minus flag", minus_n, 1'b1);
        check("reset outputs", {last_count, temp_trig, conv_pulse, store_cmd, digit}, 8'h00);
        @(posedge core_clk);
        rstn <= 1'b1;
        $display("test reset done");
    endtask

    task automatic test_trig();
        int n;
        wait_hi(1, n);
        wait_hi(1, n);
        check("trigger period", 16'(n), 16'(20 * 2 * DIV));
        $display("test trigger done");
    endtask

    task automatic test_convert(input int t, input logic neg, input logic [15:0] prev);
        int n;
        wait_hi(0, n);
        check("digits held", shown, prev);
        @(posedge core_clk);
        #1;
        check("full count width", last_count, 1'b0);
        check("conversion start", conv_pulse, 1'b1);
        repeat (2 * DIV * t - 2) @(posedge core_clk);
        check("pulse held", conv_pulse, 1'b1);
        zero_cross <= 1'b1;
        input_negative <= neg;
        @(posedge core_clk);
        zero_cross <= 1'b0;
        #1;
        check("store strobe", store_cmd, 1'b1);
        check("conversion end", conv_pulse, 1'b0);
        check("minus flag", minus_n, !neg);
        @(posedge core_clk);
        #1;
        check("strobe width", store_cmd, 1'b0);
        repeat (20) @(posedge core_clk);
        #1;
        check("stored digits", shown, {4'(t / 1000), 4'(t / 100 % 10), 4'(t / 10 % 10), 4'(t % 10)});
        check("shown sign", minus_shown, neg);
        @(posedge core_clk);
        zero_cross <= 1'b1;
        @(posedge core_clk);
        zero_cross <= 1'b0;
        #1;
        check("idle crossing", store_cmd, 1'b0);
        check("idle pulse", conv_pulse, 1'b0);
        $display("test convert done");
    endtask

    task automatic test_count();
        check("full count period", 16'(lc_gap), 16'(8000 * 2 * DIV));
        $display("test count done");
    endtask

    initial begin
        test_reset();
        test_trig();
        test_convert(1235, 1'b1, 16'h0000);
        test_convert(6785, 1'b0, 16'h1235);
        test_count();
        wrap_up();
    end
endmodule

`default_nettype wire
